// *** rtl/odri_regs.sv ***
// odri_regs: device-role register bank with control endpoint and interrupt IN endpoint logic
`timescale 1ns/100ps

// Overview of operation
// - enable bits 10:0 gate each device event onto the interrupt; upper bits reserved
// - writing one to a status bit clears it; zero leaves it
// - bits 10, 9, 4 set on OUT-direction DMA completion to memory
// - bits 8, 3, 2, 1 set on IN-direction DMA completion from memory
// - bit 0 sets when setup packet DMA into memory completes
// - bits 7, 6, 5 set on bus reset, resume while suspended, suspend
// - address pending keeps default address until status-stage zero-length packet clears it
// - read-only speed bit 18 resets to one, one means full speed
// - writing one to bit 16 pulses toggle-check clear, bit self-clears
// - soft reset bit 12 resets to one; zero holds peripheral in reset
// - test field bits 11:8 select J, K, SE0_NAK, test packet one-hot
// - control request acknowledged, copied to request pointer, interrupt raised
// - descriptor bit 1 picks ACK when one, STALL when zero
// - completion bit 0 clears itself once the device acts on it
// - interrupt IN endpoint active only while enable bit 31 is one
// - bits 30:23 poll interval, counted in frames or microframes by speed
// - halt bit 13 makes the endpoint answer with STALL
// - size code 12:10 means 8 bytes doubling; default 64 bytes
module odri_regs
    import odri_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rd_valid,
    output logic dev_irq,
    input wire logic [NUM_EVT-1:0] dev_event,
    input wire logic speed_full,
    input wire logic status_zlp_sent,
    input wire logic setup_rx,
    output logic setup_ack,
    output logic setup_dma_req,
    output logic [31:0] setup_dma_addr,
    output logic ctrl_resp_valid,
    output logic ctrl_resp_ack,
    output logic [31:0] ctrl_resp_addr,
    input wire logic ctrl_resp_taken,
    output logic [SA_ADDR_W-1:0] peripheral_address,
    output logic use_default_address,
    output logic address_pending,
    output logic configuration_complete,
    output logic out_toggle_clear,
    output logic core_rst_n,
    output logic test_j,
    output logic test_k,
    output logic test_se0_nak,
    output logic test_packet,
    input wire logic frame_tick,
    input wire logic microframe_tick,
    output logic ep1_active,
    output logic ep1_halt_resp,
    output logic ep1_poll,
    output logic [EP_MPS_W-1:0] ep1_packet_size_limit,
    output logic [10:0] ep1_max_bytes,
    output logic [31:0] ep1_buffer_pointer
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic [31:0] be_mask;
    logic wr_en_reg;
    logic wr_status;
    logic wr_sa;
    logic wr_req;
    logic wr_cin;
    logic wr_ep1c;
    logic wr_ep1p;

    assign be_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    assign wr_en_reg = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
    assign wr_status = reg_wr && (reg_addr == OFS_IRQ_STATUS);
    assign wr_sa = reg_wr && (reg_addr == OFS_STATE_ADDR);
    assign wr_req = reg_wr && (reg_addr == OFS_REQ_PTR);
    assign wr_cin = reg_wr && (reg_addr == OFS_CIN_DESC);
    assign wr_ep1c = reg_wr && (reg_addr == OFS_EP1_CTRL);
    assign wr_ep1p = reg_wr && (reg_addr == OFS_EP1_PTR);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
                                          input logic [31:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    // ------------------------------------------------------------------
    // interrupt enable and status
    // ------------------------------------------------------------------
    logic [NUM_EVT-1:0] irq_enable_reg;
    logic [NUM_EVT-1:0] irq_status_reg;
    logic [NUM_EVT-1:0] status_clr;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_reg <= '0;
        end else if (wr_en_reg) begin
            irq_enable_reg <= NUM_EVT'(merge(32'(irq_enable_reg), be_mask, reg_wdata));
        end
    end

    assign status_clr = wr_status ? NUM_EVT'(reg_wdata & be_mask) : '0;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~status_clr) | dev_event;
        end
    end

    assign dev_irq = |(irq_status_reg & irq_enable_reg);

    // ------------------------------------------------------------------
    // device state and address
    // ------------------------------------------------------------------
    logic pending_reg;
    logic speed_reg;
    logic cfg_done_reg;
    logic toggle_clr_reg;
    logic soft_rst_reg;
    logic [SA_TEST_W-1:0] test_reg;
    logic [SA_ADDR_W-1:0] addr_reg;
    logic [31:0] sa_new;

    assign sa_new = merge(32'h0000_0000, be_mask, reg_wdata);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= 1'b0;
            addr_reg <= SA_ADDR_RST;
        end else begin
            if (wr_sa && reg_be[2]) begin
                pending_reg <= sa_new[SA_PENDING];
            end else if (status_zlp_sent) begin
                pending_reg <= 1'b0;
            end
            if (wr_sa && reg_be[0]) begin
                addr_reg <= sa_new[SA_ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_reg <= 1'b1;
        end else begin
            speed_reg <= speed_full;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_done_reg <= 1'b0;
            soft_rst_reg <= 1'b1;
            test_reg <= '0;
        end else if (wr_sa) begin
            if (reg_be[2]) begin
                cfg_done_reg <= sa_new[SA_CFG_DONE];
            end
            if (reg_be[1]) begin
                soft_rst_reg <= sa_new[SA_SOFT_RST];
                test_reg <= sa_new[SA_TEST_LO +: SA_TEST_W];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_clr_reg <= 1'b0;
        end else begin
            toggle_clr_reg <= wr_sa && reg_be[2] && sa_new[SA_TOGGLE_CLR];
        end
    end

    assign peripheral_address = addr_reg;
    assign address_pending = pending_reg;
    assign use_default_address = pending_reg;
    assign configuration_complete = cfg_done_reg;
    assign out_toggle_clear = toggle_clr_reg;
    assign core_rst_n = rst_n && soft_rst_reg;
    assign test_j = test_reg[0];
    assign test_k = test_reg[1];
    assign test_se0_nak = test_reg[2];
    assign test_packet = test_reg[3];

    // ------------------------------------------------------------------
    // control endpoint request and response
    // ------------------------------------------------------------------
    logic [31:PTR_LO] req_ptr_reg;
    logic [31:PTR_LO] cin_ptr_reg;
    logic cin_ack_reg;
    logic cin_done_reg;
    logic setup_ack_reg;
    odri_ctl_e ctl_state;
    logic [31:0] req_new;
    logic [31:0] cin_new;

    assign req_new = merge({req_ptr_reg, 2'b00}, be_mask, reg_wdata);
    assign cin_new = merge({cin_ptr_reg, cin_ack_reg, cin_done_reg}, be_mask, reg_wdata);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ptr_reg <= '0;
        end else if (wr_req) begin
            req_ptr_reg <= req_new[31:PTR_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cin_ptr_reg <= '0;
            cin_ack_reg <= 1'b0;
        end else if (wr_cin) begin
            cin_ptr_reg <= cin_new[31:PTR_LO];
            cin_ack_reg <= cin_new[CIN_ACK];
        end
    end

    // software re-arming in the taking cycle wins, so no completion is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cin_done_reg <= 1'b0;
        end else if (wr_cin && reg_be[0]) begin
            cin_done_reg <= cin_new[CIN_DONE];
        end else if (ctl_state == ODRI_CTL_RESPOND && ctrl_resp_taken) begin
            cin_done_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_state <= ODRI_CTL_IDLE;
        end else begin
            unique case (ctl_state)
                ODRI_CTL_IDLE: begin
                    if (setup_rx) begin
                        ctl_state <= ODRI_CTL_SETUP_DMA;
                    end
                end
                ODRI_CTL_SETUP_DMA: begin
                    if (dev_event[EVT_SETUP]) begin
                        ctl_state <= ODRI_CTL_WAIT_SW;
                    end
                end
                ODRI_CTL_WAIT_SW: begin
                    if (cin_done_reg) begin
                        ctl_state <= ODRI_CTL_RESPOND;
                    end
                end
                ODRI_CTL_RESPOND: begin
                    if (ctrl_resp_taken) begin
                        ctl_state <= ODRI_CTL_IDLE;
                    end
                end
            endcase
        end
    end

    // a setup is acknowledged only in idle; one arriving while a request is in progress is ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_ack_reg <= 1'b0;
        end else begin
            setup_ack_reg <= setup_rx && (ctl_state == ODRI_CTL_IDLE);
        end
    end

    assign setup_ack = setup_ack_reg;
    assign setup_dma_req = (ctl_state == ODRI_CTL_SETUP_DMA);
    assign setup_dma_addr = {req_ptr_reg, 2'b00};
    assign ctrl_resp_valid = (ctl_state == ODRI_CTL_RESPOND);
    assign ctrl_resp_ack = cin_ack_reg;
    assign ctrl_resp_addr = {cin_ptr_reg, 2'b00};

    // ------------------------------------------------------------------
    // interrupt IN endpoint
    // ------------------------------------------------------------------
    logic ep1_en_reg;
    logic [EP_IVL_W-1:0] ep1_ivl_reg;
    logic ep1_halt_reg;
    logic [EP_MPS_W-1:0] ep1_mps_reg;
    logic [EP_NUM_W-1:0] ep1_num_reg;
    logic [EP_TYPE_W-1:0] ep1_type_reg;
    logic [31:0] ep1_ptr_reg;
    logic [31:0] ep1c_cur;
    logic [31:0] ep1c_new;
    logic [EP_IVL_W-1:0] poll_cnt_reg;
    logic poll_reg;
    logic tick;

    assign ep1c_cur = {ep1_en_reg, ep1_ivl_reg, 9'h000, ep1_halt_reg, ep1_mps_reg,
                       1'b1, ep1_num_reg, 2'b00, ep1_type_reg};
    assign ep1c_new = merge(ep1c_cur, be_mask, reg_wdata);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ep1_en_reg <= 1'b0;
            ep1_ivl_reg <= '0;
            ep1_halt_reg <= 1'b0;
            ep1_mps_reg <= EP1_MPS_RST;
            ep1_num_reg <= '0;
            ep1_type_reg <= '0;
        end else if (wr_ep1c) begin
            ep1_en_reg <= ep1c_new[EP_ENABLE];
            ep1_ivl_reg <= ep1c_new[EP_IVL_LO +: EP_IVL_W];
            ep1_halt_reg <= ep1c_new[EP_HALT];
            ep1_mps_reg <= ep1c_new[EP_MPS_LO +: EP_MPS_W];
            ep1_num_reg <= ep1c_new[EP_NUM_LO +: EP_NUM_W];
            ep1_type_reg <= ep1c_new[EP_TYPE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ep1_ptr_reg <= '0;
        end else if (wr_ep1p) begin
            ep1_ptr_reg <= merge(ep1_ptr_reg, be_mask, reg_wdata);
        end
    end

    // full speed counts frames, high speed counts microframes
    assign tick = speed_reg ? frame_tick : microframe_tick;

    // interval zero behaves as one so the endpoint is never starved
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_cnt_reg <= '0;
            poll_reg <= 1'b0;
        end else if (!ep1_en_reg) begin
            poll_cnt_reg <= '0;
            poll_reg <= 1'b0;
        end else if (tick) begin
            if (poll_cnt_reg + 8'h01 >= ep1_ivl_reg) begin
                poll_cnt_reg <= '0;
                poll_reg <= 1'b1;
            end else begin
                poll_cnt_reg <= poll_cnt_reg + 8'h01;
                poll_reg <= 1'b0;
            end
        end else begin
            poll_reg <= 1'b0;
        end
    end

    assign ep1_active = ep1_en_reg;
    assign ep1_halt_resp = ep1_en_reg && ep1_halt_reg;
    assign ep1_poll = poll_reg;
    assign ep1_packet_size_limit = ep1_mps_reg;
    assign ep1_max_bytes = MPS_BASE_BYTES << ep1_mps_reg;
    assign ep1_buffer_pointer = ep1_en_reg ? ep1_ptr_reg : 32'h0000_0000;

    // ------------------------------------------------------------------
    // plain storage for the rest of the map
    // ------------------------------------------------------------------
    logic [31:0] plain_reg [NUM_PLAIN];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PLAIN; i++) begin
                plain_reg[i] <= PLAIN_RST[i];
            end
        end else begin
            for (int i = 0; i < NUM_PLAIN; i++) begin
                if (reg_wr && reg_addr == PLAIN_OFS[i]) begin
                    plain_reg[i] <= merge(plain_reg[i], be_mask, reg_wdata);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read path, one cycle latency, unmapped reads zero
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr)
            OFS_IRQ_ENABLE: rd_mux = 32'(irq_enable_reg);
            OFS_IRQ_STATUS: rd_mux = 32'(irq_status_reg);
            OFS_STATE_ADDR: begin
                rd_mux[SA_PENDING] = pending_reg;
                rd_mux[SA_SPEED] = speed_reg;
                rd_mux[SA_CFG_DONE] = cfg_done_reg;
                rd_mux[SA_SOFT_RST] = soft_rst_reg;
                rd_mux[SA_TEST_LO +: SA_TEST_W] = test_reg;
                rd_mux[SA_ADDR_W-1:0] = addr_reg;
            end
            OFS_REQ_PTR: rd_mux = {req_ptr_reg, 2'b00};
            OFS_CIN_DESC: rd_mux = {cin_ptr_reg, cin_ack_reg, cin_done_reg};
            OFS_EP1_CTRL: rd_mux = ep1c_cur;
            OFS_EP1_PTR: rd_mux = ep1_ptr_reg;
            default: begin
                for (int i = 0; i < NUM_PLAIN; i++) begin
                    if (reg_addr == PLAIN_OFS[i]) begin
                        rd_mux = plain_reg[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule : odri_regs

// *** rtl/odri_pkg.sv ***
// odri_pkg: offsets, field positions, reset values and types for the device register bank
package odri_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_STATE_ADDR = 8'h08;
    localparam logic [7:0] OFS_REQ_PTR = 8'h0c;
    localparam logic [7:0] OFS_CIN_DESC = 8'h10;
    localparam logic [7:0] OFS_EP1_CTRL = 8'h14;
    localparam logic [7:0] OFS_EP1_PTR = 8'h18;

    // registers kept as plain storage for software
    localparam int NUM_PLAIN = 21;
    localparam logic [7:0] PLAIN_OFS [NUM_PLAIN] = '{
        8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44,
        8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h70, 8'h74, 8'h78, 8'h7c, 8'h84};
    localparam logic [31:0] PLAIN_RST [NUM_PLAIN] = '{
        32'h0000_0200, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_00c0, 32'h0000_0000, 32'h0000_0000, 32'h002d_c46a, 32'h005b_88d0,
        32'h0004_c471, 32'h001b_7740, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0200, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000};

    // device events / status bits
    localparam int NUM_EVT = 11;
    localparam int EVT_SETUP = 0;
    localparam int EVT_BUS_RESET = 7;
    localparam int EVT_RESUME = 6;
    localparam int EVT_SUSPEND = 5;

    // state/address register fields
    localparam int SA_PENDING = 19;
    localparam int SA_SPEED = 18;
    localparam int SA_CFG_DONE = 17;
    localparam int SA_TOGGLE_CLR = 16;
    localparam int SA_SOFT_RST = 12;
    localparam int SA_TEST_LO = 8;
    localparam int SA_TEST_W = 4;
    localparam int SA_ADDR_W = 7;
    localparam logic [SA_ADDR_W-1:0] SA_ADDR_RST = 7'h00;

    // descriptor pointer fields
    localparam int PTR_LO = 2;
    localparam int CIN_ACK = 1;
    localparam int CIN_DONE = 0;

    // interrupt endpoint control fields
    localparam int EP_ENABLE = 31;
    localparam int EP_IVL_LO = 23;
    localparam int EP_IVL_W = 8;
    localparam int EP_HALT = 13;
    localparam int EP_MPS_LO = 10;
    localparam int EP_MPS_W = 3;
    localparam int EP_DIR = 9;
    localparam int EP_NUM_LO = 5;
    localparam int EP_NUM_W = 4;
    localparam int EP_TYPE_W = 3;
    localparam logic [EP_MPS_W-1:0] EP1_MPS_RST = 3'h3;
    localparam logic [10:0] MPS_BASE_BYTES = 11'h008;

    typedef enum logic [1:0] {
        ODRI_CTL_IDLE,
        ODRI_CTL_SETUP_DMA,
        ODRI_CTL_WAIT_SW,
        ODRI_CTL_RESPOND
    } odri_ctl_e;
endpackage : odri_pkg

// *** dv/odri_props.sv ***
// odri_props: concurrent checks on the device register bank ports
`timescale 1ns/100ps
module odri_props
    import odri_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic dev_irq,
    input wire logic [NUM_EVT-1:0] dev_event,
    input wire logic status_zlp_sent,
    input wire logic setup_rx,
    input wire logic setup_ack,
    input wire logic setup_dma_req,
    input wire logic ctrl_resp_valid,
    input wire logic ctrl_resp_taken,
    input wire logic address_pending,
    input wire logic out_toggle_clear,
    input wire logic ep1_active,
    input wire logic ep1_halt_resp,
    input wire logic ep1_poll,
    input wire logic [EP_MPS_W-1:0] ep1_packet_size_limit,
    input wire logic [10:0] ep1_max_bytes,
    input wire logic [31:0] ep1_buffer_pointer
);
    logic sa_wr;
    assign sa_wr = reg_wr && reg_addr == OFS_STATE_ADDR && reg_be[2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_irq_cleared: assert property (reg_wr && reg_addr == OFS_IRQ_STATUS &&
        &reg_be[1:0] && &reg_wdata[10:0] && dev_event == '0 |=> !dev_irq)
        else $error("irq left up after full clear");
    a_toggle_pulse: assert property (out_toggle_clear == $past(sa_wr && reg_wdata[16]))
        else $error("toggle clear pulse wrong");
    a_setup_ack: assert property (setup_ack |-> setup_dma_req && $past(setup_rx))
        else $error("setup ack without request");
    a_dma_done: assert property (setup_dma_req && dev_event[EVT_SETUP] |=> !setup_dma_req)
        else $error("setup dma request stuck");
    a_resp_hold: assert property (ctrl_resp_valid && !ctrl_resp_taken |=> ctrl_resp_valid)
        else $error("response dropped early");
    a_resp_done: assert property (ctrl_resp_valid && ctrl_resp_taken |=> !ctrl_resp_valid)
        else $error("response not retired");
    a_zlp_clear: assert property (status_zlp_sent && !(sa_wr && reg_wdata[SA_PENDING])
        |=> !address_pending)
        else $error("pending address not cleared");
    a_halt_gated: assert property (ep1_halt_resp |-> ep1_active)
        else $error("halt while endpoint off");
    a_size_bytes: assert property (ep1_max_bytes == (MPS_BASE_BYTES << ep1_packet_size_limit))
        else $error("size code decode wrong");
    a_ptr_gated: assert property (!ep1_active |-> ep1_buffer_pointer == 32'h0000_0000)
        else $error("pointer visible while off");
    a_poll_gated: assert property (ep1_poll |-> $past(ep1_active))
        else $error("poll while endpoint off");
endmodule : odri_props

// *** dv/odri_host_model.sv ***
// odri_host_model: peer host stand-in for setup, status stage and frame ticks
`timescale 1ns/100ps
module odri_host_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [3:0] slow,
    input wire logic ctrl_resp_valid,
    output logic setup_rx = 1'b0,
    output logic ctrl_resp_taken = 1'b0,
    output logic status_zlp_sent = 1'b0,
    output logic frame_tick = 1'b0,
    output logic microframe_tick = 1'b0
);
    logic [3:0] wait_cnt = 4'h0;
    logic [2:0] tick_cnt = 3'h0;
    // ticks scaled down: microframe every 2 cycles, frame every 8
    always @(posedge ref_clk) begin
        setup_rx <= go;
        tick_cnt <= tick_cnt + 3'h1;
        microframe_tick <= tick_cnt[0];
        frame_tick <= tick_cnt == 3'h7;
        ctrl_resp_taken <= 1'b0;
        status_zlp_sent <= ctrl_resp_taken;
        if (ctrl_resp_valid && !ctrl_resp_taken) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == slow) begin
                ctrl_resp_taken <= 1'b1;
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : odri_host_model

// *** dv/tb_odri_regs.sv ***
// tb_odri_regs: register-level tests of the device register bank
`timescale 1ns/100ps
module tb_odri_regs;
    import odri_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [NUM_EVT-1:0] dev_event = '0;
    logic speed_full = 1'b1;
    logic go = 1'b0;
    logic [3:0] slow = 4'h0;
    logic setup_rx, ctrl_resp_taken, status_zlp_sent, frame_tick, microframe_tick;
    logic reg_rd_valid, dev_irq, setup_ack, setup_dma_req, ctrl_resp_valid, ctrl_resp_ack;
    logic use_default_address, address_pending, configuration_complete, out_toggle_clear;
    logic core_rst_n, test_j, test_k, test_se0_nak, test_packet, ep1_active, ep1_halt_resp;
    logic ep1_poll;
    logic [31:0] reg_rdata, setup_dma_addr, ctrl_resp_addr, ep1_buffer_pointer;
    logic [6:0] peripheral_address;
    logic [2:0] ep1_packet_size_limit;
    logic [10:0] ep1_max_bytes;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int i, k;
    odri_regs i_odri_regs (.*);
    odri_host_model i_odri_host_model (.*);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    task close_out;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : clk
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= b;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        chk(reg_rd_valid, 1'b1);
    endtask : rd
    task pulse(input int n);
        @(posedge ref_clk) dev_event[n] <= 1'b1;
        @(posedge ref_clk) dev_event[n] <= 1'b0;
    endtask : pulse
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        clk(3);
        rd(OFS_STATE_ADDR, 32'h0004_1000);
        rd(OFS_EP1_CTRL, 32'h0000_0e00);
        for (i = 0; i < NUM_PLAIN; i++) rd(PLAIN_OFS[i], PLAIN_RST[i]);
        rd(8'h60, 32'h0000_0000);
        wr(OFS_IRQ_ENABLE, 32'hffff_ffff, 4'hf);
        rd(OFS_IRQ_ENABLE, 32'h0000_07ff);
        for (i = 0; i < NUM_EVT; i++) begin
            wr(OFS_IRQ_ENABLE, 32'h0000_0000, 4'hf);
            pulse(i);
            rd(OFS_IRQ_STATUS, 32'h1 << i);
            chk(dev_irq, 1'b0);
            wr(OFS_IRQ_ENABLE, 32'h1 << i, 4'hf);
            chk(dev_irq, 1'b1);
            wr(OFS_IRQ_STATUS, ~(32'h1 << i), 4'hf);
            rd(OFS_IRQ_STATUS, 32'h1 << i);
            wr(OFS_IRQ_STATUS, 32'h1 << i, 4'hf);
            chk(dev_irq, 1'b0);
        end
        wr(OFS_IRQ_STATUS, 32'hffff_ffff, 4'hf);
        wr(OFS_STATE_ADDR, 32'h000b_1155, 4'hf);
        chk(out_toggle_clear, 1'b1);
        rd(OFS_STATE_ADDR, 32'h000e_1155);
        chk({address_pending, use_default_address, configuration_complete,
             peripheral_address}, {3'b111, 7'h55});
        for (i = 0; i < 4; i++) begin
            wr(OFS_STATE_ADDR, 32'h0000_1000 | (32'h100 << i), 4'h2);
            chk({test_packet, test_se0_nak, test_k, test_j}, 32'h1 << i);
        end
        wr(OFS_STATE_ADDR, 32'h0000_0000, 4'h2);
        chk(core_rst_n, 1'b0);
        wr(OFS_STATE_ADDR, 32'h0000_1000, 4'h2);
        chk(core_rst_n, 1'b1);
        @(posedge ref_clk) speed_full <= 1'b0;
        rd(OFS_STATE_ADDR, 32'h000a_1055);
        wr(OFS_REQ_PTR, 32'h1234_5677, 4'hf);
        rd(OFS_REQ_PTR, 32'h1234_5674);
        chk(setup_dma_addr, 32'h1234_5674);
        // pass 0 answers ACK promptly, pass 1 STALL after a slow host
        for (i = 0; i < 2; i++) begin
            slow <= 4'(i * 5);
            @(posedge ref_clk) go <= 1'b1;
            @(posedge ref_clk) go <= 1'b0;
            clk(3);
            chk(setup_dma_req, 1'b1);
            pulse(EVT_SETUP);
            rd(OFS_IRQ_STATUS, 32'h1);
            wr(OFS_IRQ_STATUS, 32'h1, 4'hf);
            wr(OFS_CIN_DESC, i ? 32'h0000_8001 : 32'h0000_8003, 4'hf);
            for (k = 0; k < 20 && ctrl_resp_valid !== 1'b1; k++) clk(1);
            chk({ctrl_resp_valid, ctrl_resp_ack}, {1'b1, ~i[0]});
            chk(ctrl_resp_addr, 32'h0000_8000);
            clk(12);
            rd(OFS_CIN_DESC, i ? 32'h0000_8000 : 32'h0000_8002);
            chk(address_pending, 1'b0);
        end
        wr(OFS_EP1_PTR, 32'hcafe_0010, 4'hf);
        chk(ep1_buffer_pointer, 32'h0);
        wr(OFS_EP1_CTRL, 32'h8180_3400, 4'hf);
        rd(OFS_EP1_CTRL, 32'h8180_3600);
        chk({ep1_active, ep1_halt_resp, ep1_max_bytes}, {2'b11, 11'd256});
        chk(ep1_buffer_pointer, 32'hcafe_0010);
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk) speed_full <= i[0];
            clk(30);
            for (k = 0; k < 40 && ep1_poll !== 1'b1; k++) clk(1);
            for (k = 1; k < 40; k++) begin
                clk(1);
                if (ep1_poll === 1'b1) break;
            end
            chk(k, i ? 24 : 6);
        end
        wr(OFS_EP1_CTRL, 32'h0000_2000, 4'hf);
        chk({ep1_active, ep1_halt_resp}, 2'b00);
        chk(ep1_buffer_pointer, 32'h0);
        close_out();
    end
endmodule : tb_odri_regs
bind odri_regs odri_props i_odri_props (.*);
